// >>> src/pbs_regs.sv
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
// power budgeting and switch status register bank on apb
module pbs_regs #(
  parameter int ENTRIES = pbs_pkg::PBS_ENTRIES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hot_reset,
  input wire logic [2:0] mode_pins,
  input wire logic downstream_common_clock_strap,
  input wire logic upstream_common_clock_strap,
  input wire logic master_mgmt_bus_slow_strap,
  input wire logic refclk_mode_strap,
  input wire logic reset_hold_strap,
  input wire logic lock_upd,
  input wire logic [2:0] lock_code,
  output logic system_allocated_flag,
  output logic [3:0] elastic_fifo_init_level,
  output logic lower_latency
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0] entry_r [ENTRIES]; // sticky power records, no reset value
  logic [7:0] sel_r; // power_data_select
  logic sa_r; // system allocated bit
  logic [3:0] marker_r; // software scratch, survives hot reset
  logic register_unlock_r; // lockable field write enable
  logic power_data_unlock_r; // record write enable
  logic [7:0] straps; // mode[2:0], then five strap bits
  logic straps_ok; // capture done
  logic [2:0] owner; // lock owner code
  logic wr_acc; // write access phase
  logic rd_acc; // read access phase
  logic [31:0] sts_word; // assembled status
  logic [31:0] rd_nxt; // read mux
  logic unmapped; // address hits nothing
  logic [2:0] operating_mode_code;
  logic [3:0] wr_idx; // record index of the current address
  logic [31:0] wr_old; // record content before a write lands
  logic [31:0] sel_rec; // record named by the data select
  logic [4:0] strap_bits; // status view of the five strap pins

  // record index for an address inside the entry window
  function automatic logic [3:0] entry_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - pbs_pkg::PBS_ENTRY_OFF;
    return d[5:2];
  endfunction : entry_idx

  // true when an address falls on one of the records
  function automatic logic is_entry(input logic [11:0] a);
    logic [3:0] i;
    i = entry_idx(a);
    return a >= pbs_pkg::PBS_ENTRY_OFF && a[1:0] == 2'b00 && 32'(i) < ENTRIES &&
      a < pbs_pkg::PBS_ENTRY_OFF + 12'(4 * ENTRIES);
  endfunction : is_entry

  ////////////////////////////////////////////////////////////////////////
  // submodules
  // straps are sampled after fundamental reset only
  pbs_strap_latch #(.WIDTH(8)) u_straps (
    .pclk(pclk),
    .presetn(presetn),
    .pins({reset_hold_strap, refclk_mode_strap, master_mgmt_bus_slow_strap,
      upstream_common_clock_strap, downstream_common_clock_strap, mode_pins}),
    .straps(straps),
    .valid(straps_ok)
  );

  pbs_lock_track u_lock (
    .pclk(pclk),
    .presetn(presetn),
    .hot_reset(hot_reset),
    .lock_upd(lock_upd),
    .lock_code(lock_code),
    .owner(owner)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign operating_mode_code = straps[2:0];
  // check helpers; the checks sample them as plain signals
  // both array reads may run past the last record; the checks only look when in range
  // so the unknown value of such a read never reaches a comparison
  assign wr_idx = entry_idx(paddr);
  assign wr_old = entry_r[wr_idx];
  assign sel_rec = entry_r[sel_r[3:0]];
  assign strap_bits = straps[7:3];
  assign unmapped = !(paddr == pbs_pkg::PBS_DSEL_OFF || paddr == pbs_pkg::PBS_DATA_OFF ||
    paddr == pbs_pkg::PBS_ALLOC_OFF || paddr == pbs_pkg::PBS_STS_OFF ||
    paddr == pbs_pkg::PBS_CTL_OFF || is_entry(paddr));

  // status word; reserved bits stay zero
  always_comb begin
    sts_word = pbs_pkg::PBS_ZERO;
    sts_word[pbs_pkg::PBS_MODE_LSB +: 3] = operating_mode_code;
    sts_word[pbs_pkg::PBS_DSCC_BIT] = straps[3];
    sts_word[pbs_pkg::PBS_USCC_BIT] = straps[4];
    sts_word[pbs_pkg::PBS_MSLOW_BIT] = straps[5];
    sts_word[pbs_pkg::PBS_REFCLK_BIT] = straps[6];
    sts_word[pbs_pkg::PBS_RHOLD_BIT] = straps[7];
    sts_word[pbs_pkg::PBS_LOCK_LSB +: 3] = owner;
    sts_word[pbs_pkg::PBS_MARK_LSB +: 4] = marker_r;
  end

  // read mux
  always_comb begin
    rd_nxt = pbs_pkg::PBS_ZERO;
    if (paddr == pbs_pkg::PBS_DSEL_OFF) begin
      rd_nxt[7:0] = sel_r;
    end else if (paddr == pbs_pkg::PBS_DATA_OFF) begin
      // out-of-range select reads zero
      if (sel_r <= pbs_pkg::PBS_MAX_SEL && 32'(sel_r) < ENTRIES) begin
        rd_nxt = entry_r[sel_r[3:0]];
      end
    end else if (paddr == pbs_pkg::PBS_ALLOC_OFF) begin
      rd_nxt[pbs_pkg::PBS_SA_BIT] = sa_r;
    end else if (paddr == pbs_pkg::PBS_STS_OFF) begin
      rd_nxt = sts_word;
    end else if (paddr == pbs_pkg::PBS_CTL_OFF) begin
      rd_nxt[pbs_pkg::PBS_REGUL_BIT] = register_unlock_r;
      rd_nxt[pbs_pkg::PBS_PDUL_BIT] = power_data_unlock_r;
    end else if (is_entry(paddr)) begin
      rd_nxt = entry_r[entry_idx(paddr)];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb response: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= pbs_pkg::PBS_ZERO;
      pslverr <= 1'b0;
    end else begin
      // pready pulses in the second access cycle
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && unmapped;
      if (rd_acc && !pready) begin
        prdata <= rd_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control unlock bits; register unlock set by reset so init can load, power unlock cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      register_unlock_r <= 1'b1;
      power_data_unlock_r <= 1'b0;
    end else if (wr_acc && pready && paddr == pbs_pkg::PBS_CTL_OFF) begin
      register_unlock_r <= pwdata[pbs_pkg::PBS_REGUL_BIT];
      // the power unlock bit is itself lockable
      if (register_unlock_r) begin
        power_data_unlock_r <= pwdata[pbs_pkg::PBS_PDUL_BIT];
      end
    end
  end

  // data select, plain read/write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= 8'h00;
    end else if (wr_acc && pready && paddr == pbs_pkg::PBS_DSEL_OFF) begin
      sel_r <= pwdata[7:0];
    end
  end

  // system allocated bit, lockable; hot reset leaves it (sticky)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa_r <= 1'b0;
    end else if (wr_acc && pready && paddr == pbs_pkg::PBS_ALLOC_OFF && register_unlock_r) begin
      sa_r <= pwdata[pbs_pkg::PBS_SA_BIT];
    end
  end

  // marker: lockable, only fundamental reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      marker_r <= pbs_pkg::PBS_MARK_RST;
    end else if (wr_acc && pready && paddr == pbs_pkg::PBS_STS_OFF && register_unlock_r) begin
      marker_r <= pwdata[pbs_pkg::PBS_MARK_LSB +: 4];
    end
  end

  // power records: no reset, so contents are undefined until loaded
  always_ff @(posedge pclk) begin
    if (wr_acc && pready && is_entry(paddr) && power_data_unlock_r) begin
      entry_r[entry_idx(paddr)] <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs to the datapath
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_allocated_flag <= 1'b0;
      elastic_fifo_init_level <= pbs_pkg::PBS_EFIFO_NORM;
      lower_latency <= 1'b0;
    end else begin
      system_allocated_flag <= sa_r;
      // lower-latency modes trim the fifo start level
      if (straps_ok && (operating_mode_code == pbs_pkg::PBS_MODE_LL ||
          operating_mode_code == pbs_pkg::PBS_MODE_EE_LL)) begin
        elastic_fifo_init_level <= pbs_pkg::PBS_EFIFO_LL;
        lower_latency <= 1'b1;
      end else begin
        elastic_fifo_init_level <= pbs_pkg::PBS_EFIFO_NORM;
        lower_latency <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence wr_locked_s;
    wr_acc && pready && is_entry(paddr) && !power_data_unlock_r;
  endsequence


  // a status read in its first access cycle; the answer stands one cycle later
  sequence sts_rd_s;
    rd_acc && !pready && paddr == pbs_pkg::PBS_STS_OFF;
  endsequence

  // a data read whose select names an existing record
  sequence data_rd_s;
    rd_acc && !pready && paddr == pbs_pkg::PBS_DATA_OFF && sel_r <= pbs_pkg::PBS_MAX_SEL;
  endsequence

  // record locking and record writes
  entry_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_locked_s |=> entry_r[$past(wr_idx)] == $past(wr_old))
    else $error("locked record was modified");
  entry_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && pready && is_entry(paddr) && power_data_unlock_r |=> entry_r[$past(wr_idx)] == $past(pwdata))
    else $error("unlocked record write lost");
  // lockable fields and the hot reset
  marker_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    !register_unlock_r |=> $stable(marker_r) && $stable(sa_r))
    else $error("lockable field changed while locked");
  marker_hot_a: assert property (@(posedge pclk) disable iff (!presetn)
    hot_reset && !wr_acc |=> $stable(marker_r)) else $error("hot reset touched marker");
  pdul_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    !register_unlock_r |=> $stable(power_data_unlock_r)) else $error("power unlock changed while locked");
  strap_hot_a: assert property (@(posedge pclk) disable iff (!presetn)
    straps_ok && hot_reset |=> $stable(strap_bits)) else $error("hot reset changed a strap bit");
  // readback of the select and data registers
  sel_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && !pready && paddr == pbs_pkg::PBS_DATA_OFF && sel_r > pbs_pkg::PBS_MAX_SEL |=> prdata == 32'h0000_0000)
    else $error("out-of-range select not zero");
  data_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_rd_s |=> prdata == $past(sel_rec))
    else $error("selected record not reported");
  dsel_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && !pready && paddr == pbs_pkg::PBS_DSEL_OFF |=> prdata[31:8] == 24'h00_0000)
    else $error("select register reserved bits not zero");
  // status word readback, field by field
  sts_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    sts_rd_s |=>
      prdata[2:0] == $past(operating_mode_code) && prdata[19:10] == 10'h000 && prdata[4:3] == 2'b00)
    else $error("status word fields wrong");
  sts_strap_a: assert property (@(posedge pclk) disable iff (!presetn)
    sts_rd_s |=> prdata[9:5] == $past(strap_bits)) else $error("strap bits wrong in status");
  sts_owner_a: assert property (@(posedge pclk) disable iff (!presetn)
    sts_rd_s |=> prdata[22:20] == $past(owner) && prdata[31:28] == $past(marker_r) && prdata[27:23] == 5'h00)
    else $error("owner or marker wrong in status");
  // flag and control readback
  sa_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && !pready && paddr == pbs_pkg::PBS_ALLOC_OFF |=> prdata == {31'h0, $past(sa_r)})
    else $error("alloc flag readback wrong");
  ctl_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && !pready && paddr == pbs_pkg::PBS_CTL_OFF |=> prdata[31:5] == 27'h000_0000 && prdata[2:0] == 3'h0)
    else $error("control reserved bits not zero");
  sa_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> system_allocated_flag == $past(sa_r)) else $error("allocated flag output lags");
  // latency trim follows the strapped mode; reserved codes stay normal
  latency_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    straps_ok && operating_mode_code[2:1] == 2'b01 |-> ##1 lower_latency ##0
      elastic_fifo_init_level == pbs_pkg::PBS_EFIFO_LL) else $error("low latency not applied");
  normal_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    straps_ok && operating_mode_code[2:1] != 2'b01 |=>
      !lower_latency && elastic_fifo_init_level == pbs_pkg::PBS_EFIFO_NORM) else $error("normal mode latency wrong");
  // bus answer timing
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready) else $error("apb answer late");
  err_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("slave error without ready");
endmodule : pbs_regs
`default_nettype wire

// >>> src/pbs_pkg.sv
// Contract
// - bit 0 flags device budget as system-allocated
// - ten sticky 32-bit power records from 0x300
// - records writable only while power-data unlock set
// - status 2:0 reports strapped operating mode
// - lower-latency modes shift elastic FIFO initial level
// - status bit 5 holds downstream common-clock strap
// - status bit 6 holds upstream common-clock strap
// - status bit 7 holds management bus slow strap
// - status bit 8 holds refclk mode strap
// - status bit 9 holds reset-hold strap
// - status 22:20 lock owner code, resets zero
// - marker 31:28 lockable, sticky across hot reset
// - lockable fields writable only while register unlock set
// - power-data unlock governs all record entries
// - data select above 9 reads zero
package pbs_pkg;
  // byte offsets on the apb bus
  localparam logic [11:0] PBS_DSEL_OFF = 12'h284; // power data select
  localparam logic [11:0] PBS_DATA_OFF = 12'h288; // selected record readout
  localparam logic [11:0] PBS_ALLOC_OFF = 12'h28C; // power_budget_alloc_flag
  localparam logic [11:0] PBS_ENTRY_OFF = 12'h300; // power_data_value_entries
  localparam logic [11:0] PBS_STS_OFF = 12'h328; // switch_status_word
  localparam logic [11:0] PBS_CTL_OFF = 12'h32C; // switch_control_word (unlock bits)
  localparam int PBS_ENTRIES = 10; // number of power records
  localparam logic [7:0] PBS_MAX_SEL = 8'h09; // highest valid select
  // field positions
  localparam int PBS_SA_BIT = 0;
  localparam int PBS_MODE_LSB = 0;
  localparam int PBS_DSCC_BIT = 5;
  localparam int PBS_USCC_BIT = 6;
  localparam int PBS_MSLOW_BIT = 7;
  localparam int PBS_REFCLK_BIT = 8;
  localparam int PBS_RHOLD_BIT = 9;
  localparam int PBS_LOCK_LSB = 20;
  localparam int PBS_MARK_LSB = 28;
  localparam int PBS_REGUL_BIT = 3;
  localparam int PBS_PDUL_BIT = 4;
  // operating mode codes
  localparam logic [2:0] PBS_MODE_NORM = 3'h0;
  localparam logic [2:0] PBS_MODE_EE = 3'h1;
  localparam logic [2:0] PBS_MODE_LL = 3'h2;
  localparam logic [2:0] PBS_MODE_EE_LL = 3'h3;
  // elastic fifo initial levels; lower value saves 8 ns
  localparam logic [3:0] PBS_EFIFO_NORM = 4'h4;
  localparam logic [3:0] PBS_EFIFO_LL = 4'h3;
  localparam int PBS_SAVE_NS = 8;
  localparam int PBS_CLK_MHZ = 100;
  localparam int PBS_SAVE_CYC = (PBS_SAVE_NS * PBS_CLK_MHZ) / 1000; // whole cycles saved
  // reset values
  localparam logic [31:0] PBS_ZERO = 32'h0000_0000;
  localparam logic [3:0] PBS_MARK_RST = 4'h0;
  localparam logic [2:0] PBS_LOCK_RST = 3'h0;
  // lock owner codes: 0 unlocked, 2..5 locked with port
  localparam logic [2:0] PBS_LOCK_MIN = 3'h2;
  localparam logic [2:0] PBS_LOCK_MAX = 3'h5;
  // strap capture sequencer
  typedef enum logic [1:0] {PBS_ST_RESET = 2'b00, PBS_ST_FILL = 2'b01, PBS_ST_CAPT = 2'b11,
    PBS_ST_RUN = 2'b10} pbs_state_t;
endpackage : pbs_pkg

// >>> src/pbs_strap_latch.sv
`timescale 1ns/100ps
`default_nettype none
// samples the straps once after fundamental reset release
module pbs_strap_latch #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] straps,
  output logic valid
);
  logic [WIDTH-1:0] sync1_r; // first stage, read only by sync2
  logic [WIDTH-1:0] sync2_r;
  pbs_pkg::pbs_state_t state_r;

  // two-flop synchroniser for pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  // wait for pipeline to fill, then capture once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= pbs_pkg::PBS_ST_RESET;
      straps <= '0;
      valid <= 1'b0;
    end else begin
      case (state_r)
        // two edges for the pin level to reach the second flop
        pbs_pkg::PBS_ST_RESET: state_r <= pbs_pkg::PBS_ST_FILL;
        pbs_pkg::PBS_ST_FILL: state_r <= pbs_pkg::PBS_ST_CAPT;
        pbs_pkg::PBS_ST_CAPT: begin
          straps <= sync2_r;
          valid <= 1'b1;
          state_r <= pbs_pkg::PBS_ST_RUN;
        end
        pbs_pkg::PBS_ST_RUN: state_r <= pbs_pkg::PBS_ST_RUN;
        default: state_r <= pbs_pkg::PBS_ST_RESET;
      endcase
    end
  end

  strap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    valid && $past(valid) |-> $stable(straps)) else $error("strap value changed after capture");
endmodule : pbs_strap_latch
`default_nettype wire

// >>> src/pbs_lock_track.sv
`timescale 1ns/100ps
`default_nettype none
// holds the lock owner code; reserved codes are refused
module pbs_lock_track (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hot_reset,
  input wire logic lock_upd,
  input wire logic [2:0] lock_code,
  output logic [2:0] owner
);
  // owner updates only with legal codes, clears on any reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owner <= pbs_pkg::PBS_LOCK_RST;
    end else if (hot_reset) begin
      owner <= pbs_pkg::PBS_LOCK_RST;
    end else if (lock_upd && (lock_code == 3'h0 ||
        (lock_code >= pbs_pkg::PBS_LOCK_MIN && lock_code <= pbs_pkg::PBS_LOCK_MAX))) begin
      owner <= lock_code;
    end
  end

  lock_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    owner != 3'h1 && owner < 3'h6) else $error("lock owner holds reserved code");
endmodule : pbs_lock_track
`default_nettype wire

// >>> tb/test_power_budget_switch_status_regs.sv
`timescale 1ns/100ps
`default_nettype none
// bench for the power budget and switch status register bank
module test_power_budget_switch_status_regs;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr; // apb side
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic hot_reset, lock_upd, sa_out, low_lat; // side pins
  logic [2:0] mode_pins, lock_code;
  logic [3:0] fifo_lvl;
  logic [4:0] st; // straps: hold, refclk, slow, us, ds
  logic [31:0] rec_m [10]; // model of the records
  logic [31:0] rd_v;
  logic err_v, sa_m, rul_m, pul_m; // model flags
  logic [3:0] mark_m;
  logic [2:0] lock_m;
  logic [2:0] lk [8] = '{3'h2, 3'h1, 3'h5, 3'h6, 3'h3, 3'h7, 3'h4, 3'h0}; // valid and reserved mixed
  integer seed = 89395;
  integer n_errors = 0;
  integer num_checks = 0;
  pbs_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hot_reset(hot_reset), .mode_pins(mode_pins), .downstream_common_clock_strap(st[0]),
    .upstream_common_clock_strap(st[1]), .master_mgmt_bus_slow_strap(st[2]), .refclk_mode_strap(st[3]),
    .reset_hold_strap(st[4]), .lock_upd(lock_upd), .lock_code(lock_code), .system_allocated_flag(sa_out),
    .elastic_fifo_init_level(fifo_lvl), .lower_latency(low_lat));
  ////////////////////////////////////////////////////////////////////////////
  // 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // verdict in one place
  task complete_run;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // compare of apb read data
  task chk_rd(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t rd got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_rd
  // compare of side outputs
  task chk_out(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t out got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_out
  // one apb transfer; waits for pready, bounded
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    integer i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      complete_run();
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // read and compare data plus error flag
  task rd(input logic [11:0] a, input logic [31:0] exp, input logic e = 1'b0);
    apb(1'b0, a, 32'h0000_0000);
    chk_rd(rd_v, exp);
    chk_out({3'h0, err_v}, {3'h0, e});
  endtask : rd
  // status word as the model sees it
  function automatic logic [31:0] sts_m();
    return {mark_m, 5'h00, lock_m, 10'h000, st, 2'h0, mode_pins};
  endfunction : sts_m
  // fundamental reset with new straps
  task do_reset(input logic [2:0] m);
    presetn <= 1'b0;
    mode_pins <= m;
    st <= 5'($random(seed)) | (m[1] ? 5'h03 : 5'h00);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk); // straps captured by 4th edge
    {sa_m, mark_m, lock_m, rul_m, pul_m} = {1'b0, 4'h0, 3'h0, 1'b1, 1'b0};
  endtask : do_reset
  // lock owner update pulse from the datapath
  task lock_ev(input logic [2:0] c);
    @(posedge pclk);
    lock_upd <= 1'b1;
    lock_code <= c;
    @(posedge pclk);
    lock_upd <= 1'b0;
    if (c == 3'h0 || (c >= 3'h2 && c <= 3'h5)) lock_m = c;
    repeat (2) @(posedge pclk);
  endtask : lock_ev
  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, hot_reset, lock_upd} = 6'h00;
    {paddr, pwdata, lock_code, mode_pins, st} = '0;
    // mode codes 0 to 3, fresh random straps each time
    for (int m = 0; m < 4; m++) begin
      do_reset(3'(m));
      chk_out({3'h0, low_lat}, {3'h0, m >= 2});
      chk_out(fifo_lvl, m >= 2 ? pbs_pkg::PBS_EFIFO_LL : pbs_pkg::PBS_EFIFO_NORM);
      rd(pbs_pkg::PBS_STS_OFF, sts_m());
      chk_out({3'h0, sa_out}, 4'h0);
    end
    // reserved bits of the flag word ignore ones
    apb(1'b1, pbs_pkg::PBS_ALLOC_OFF, 32'hFFFF_FFFF);
    sa_m = 1'b1;
    rd(pbs_pkg::PBS_ALLOC_OFF, 32'h0000_0001);
    chk_out({3'h0, sa_out}, {3'h0, sa_m});
    // open the records, fill all ten
    apb(1'b1, pbs_pkg::PBS_CTL_OFF, 32'h0000_0018);
    pul_m = 1'b1;
    rd(pbs_pkg::PBS_CTL_OFF, {27'h000_0000, pul_m, rul_m, 3'h0});
    for (int k = 0; k < 10; k++) begin
      rec_m[k] = $random(seed);
      apb(1'b1, pbs_pkg::PBS_ENTRY_OFF + 12'(4 * k), rec_m[k]);
    end
    for (int k = 0; k < 10; k++) begin
      rd(pbs_pkg::PBS_ENTRY_OFF + 12'(4 * k), rec_m[k]);
      apb(1'b1, pbs_pkg::PBS_DSEL_OFF, 32'(k));
      rd(pbs_pkg::PBS_DATA_OFF, rec_m[k]);
    end
    // selects past the last record read zero
    apb(1'b1, pbs_pkg::PBS_DSEL_OFF, 32'hFFFF_FF0A);
    rd(pbs_pkg::PBS_DSEL_OFF, 32'h0000_000A);
    rd(pbs_pkg::PBS_DATA_OFF, 32'h0000_0000);
    apb(1'b1, pbs_pkg::PBS_DSEL_OFF, 32'h0000_00FF);
    rd(pbs_pkg::PBS_DATA_OFF, 32'h0000_0000);
    // marker while unlocked
    apb(1'b1, pbs_pkg::PBS_STS_OFF, 32'hFFFF_FFFF);
    mark_m = 4'hF;
    rd(pbs_pkg::PBS_STS_OFF, sts_m());
    // lock owner codes, reserved ones interleaved
    for (int c = 0; c < 8; c++) begin
      lock_ev(lk[c]);
      rd(pbs_pkg::PBS_STS_OFF, sts_m());
    end
    // hot reset drops owner, keeps marker
    lock_ev(3'h3);
    @(posedge pclk);
    hot_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    hot_reset <= 1'b0;
    lock_m = 3'h0;
    rd(pbs_pkg::PBS_STS_OFF, sts_m());
    // records locked again: writes dropped
    apb(1'b1, pbs_pkg::PBS_CTL_OFF, 32'h0000_0008);
    pul_m = 1'b0;
    rd(pbs_pkg::PBS_CTL_OFF, {27'h000_0000, pul_m, rul_m, 3'h0});
    apb(1'b1, pbs_pkg::PBS_ENTRY_OFF + 12'h008, ~rec_m[2]);
    rd(pbs_pkg::PBS_ENTRY_OFF + 12'h008, rec_m[2]);
    // register lock: flag and marker hold
    apb(1'b1, pbs_pkg::PBS_CTL_OFF, 32'h0000_0000);
    rul_m = 1'b0;
    // power unlock is itself lockable: this write must not open the records
    apb(1'b1, pbs_pkg::PBS_CTL_OFF, 32'h0000_0010);
    rd(pbs_pkg::PBS_CTL_OFF, {27'h000_0000, pul_m, rul_m, 3'h0});
    apb(1'b1, pbs_pkg::PBS_ALLOC_OFF, 32'h0000_0000);
    apb(1'b1, pbs_pkg::PBS_STS_OFF, 32'h0000_0000);
    rd(pbs_pkg::PBS_ALLOC_OFF, 32'h0000_0001);
    rd(pbs_pkg::PBS_STS_OFF, sts_m());
    chk_out({3'h0, sa_out}, 4'h1);
    // unmapped place answers with an error
    rd(12'h100, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h3FC, 32'h1234_5678);
    chk_out({3'h0, err_v}, 4'h1);
    // fundamental reset clears marker and flag
    do_reset(3'h1);
    rd(pbs_pkg::PBS_STS_OFF, sts_m());
    rd(pbs_pkg::PBS_ALLOC_OFF, 32'h0000_0000);
    complete_run();
  end
endmodule : test_power_budget_switch_status_regs
`default_nettype wire
